// *** common/fsp_pkg.sv ***
/*
  Constants for the flash self-program sequencer: command codes, address
  layout, timing counts.
  Assumes a 10 MHz core clock and a flash array modelled outside this block.
*/
package fsp_pkg;

  // ***********************************************
  // sizes
  // ***********************************************
  localparam int unsigned FSP_ADDR_W = 16;
  localparam int unsigned FSP_WORD_BITS = 5;
  localparam int unsigned FSP_PAGE_WORDS = 32;
  localparam int unsigned FSP_PAGE_BITS = 9;
  localparam int unsigned FSP_PAGE_LSB = FSP_WORD_BITS + 1;
  localparam int unsigned FSP_CMD_W = 7;
  localparam logic [FSP_PAGE_BITS-1:0] FSP_BOOT_FIRST_PAGE = 9'h1_E0;
  localparam logic [15:0] FSP_BLANK_WORD = 16'hFFFF;
  localparam logic [15:0] FSP_CRC_SEED = 16'hFFFF;
  localparam logic [15:0] FSP_CRC_POLY = 16'h1021;

  // ***********************************************
  // command codes
  // ***********************************************
  localparam logic [6:0] FSP_CMD_NOP = 7'h00;
  localparam logic [6:0] FSP_CMD_LOAD_BUF = 7'h23;
  localparam logic [6:0] FSP_CMD_ERASE_BUF = 7'h26;
  localparam logic [6:0] FSP_CMD_ERASE_PAGE = 7'h2B;
  localparam logic [6:0] FSP_CMD_WRITE_PAGE = 7'h2E;
  localparam logic [6:0] FSP_CMD_EW_PAGE = 7'h2F;
  localparam logic [6:0] FSP_CMD_RANGE_CRC = 7'h3A;
  localparam logic [6:0] FSP_CMD_ERASE_APP = 7'h20;
  localparam logic [6:0] FSP_CMD_ERASE_APP_PG = 7'h22;
  localparam logic [6:0] FSP_CMD_WRITE_APP_PG = 7'h24;
  localparam logic [6:0] FSP_CMD_EW_APP_PG = 7'h25;
  localparam logic [6:0] FSP_CMD_APP_CRC = 7'h38;
  localparam logic [6:0] FSP_CMD_ERASE_BOOT_PG = 7'h2A;
  localparam logic [6:0] FSP_CMD_WRITE_BOOT_PG = 7'h2C;
  localparam logic [6:0] FSP_CMD_EW_BOOT_PG = 7'h2D;
  localparam logic [6:0] FSP_CMD_BOOT_CRC = 7'h39;
  localparam logic [6:0] FSP_CMD_ERASE_SIG = 7'h18;
  localparam logic [6:0] FSP_CMD_WRITE_SIG = 7'h1A;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int unsigned FSP_CLK_HZ = 10_000_000;
  localparam int unsigned FSP_ERASE_US = 100;
  localparam int unsigned FSP_PROG_US = 100;
  localparam int unsigned FSP_ERASE_CYC = (FSP_ERASE_US * (FSP_CLK_HZ / 1_000_000) > 0) ?
                                          FSP_ERASE_US * (FSP_CLK_HZ / 1_000_000) : 1;
  localparam int unsigned FSP_PROG_CYC = (FSP_PROG_US * (FSP_CLK_HZ / 1_000_000) > 0) ?
                                         FSP_PROG_US * (FSP_CLK_HZ / 1_000_000) : 1;
  localparam int unsigned FSP_TMR_W = 12;

endpackage

// *** common/fsp_flash_if.sv ***
/*
  Page buffer access between the sequencer and its page buffer.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface fsp_buf_if;
  import fsp_pkg::*;
  logic wr_en;
  logic [FSP_WORD_BITS-1:0] wr_idx;
  logic [15:0] wr_data;
  logic clear;
  logic [FSP_WORD_BITS-1:0] rd_idx;
  logic [15:0] rd_data;
  modport owner (output wr_en, output wr_idx, output wr_data, output clear, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input clear, input rd_idx, output rd_data);
endinterface

// *** rtl/fsp_page_buf.sv ***
/*
  Flash page buffer: one word per location, cleared to all ones.
  Assumes the owner never writes and clears in the same cycle.
*/
`timescale 1ns/1ps
module fsp_page_buf
  import fsp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  fsp_buf_if.store bus
);
  logic [15:0] mem_reg [FSP_PAGE_WORDS];

  assign bus.rd_data = mem_reg[bus.rd_idx];

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < FSP_PAGE_WORDS; i++)
    begin
      if (!reset_n || bus.clear)
        mem_reg[i] <= FSP_BLANK_WORD;
      else if (bus.wr_en && bus.wr_idx == i[FSP_WORD_BITS-1:0])
        mem_reg[i] <= bus.wr_data;
    end
  end

  a_clear_blank: assert property (@(posedge mclk) disable iff (!reset_n)
    bus.clear |=> mem_reg[0] == FSP_BLANK_WORD && mem_reg[FSP_PAGE_WORDS-1] == FSP_BLANK_WORD)
    else $error("page buffer not blank after clear");
endmodule // fsp_page_buf

// *** rtl/fsp_crc16.sv ***
/*
  Byte-serial crc16 update stage.
  Assumes the caller seeds and sequences bytes.
*/
`timescale 1ns/1ps
module fsp_crc16
  import fsp_pkg::*;
(
  input wire logic [15:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc_out
);
  always_comb
  begin
    logic [15:0] c;
    c = crc_in ^ {byte_in, 8'h00};
    for (int b = 0; b < 8; b++)
      c = c[15] ? ({c[14:0], 1'b0} ^ FSP_CRC_POLY) : {c[14:0], 1'b0};
    crc_out = c;
  end
endmodule // fsp_crc16

// *** rtl/fsp_sequencer.sv ***
/*
  Flash self-program command sequencer: decodes the command field, takes
  load / store / execute triggers from the core and drives the flash array.
  Assumes the flash array answers reads combinationally in the same cycle
  and performs erase/program when strobed; the core's unlock window is
  delivered as a level on unlock_ok.
*/
`timescale 1ns/1ps
module fsp_sequencer
  import fsp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [FSP_CMD_W-1:0] command_sel,
  input wire logic command_execute_bit,
  input wire logic unlock_ok,
  input wire logic program_memory_load_instr,
  input wire logic program_memory_store_instr,
  input wire logic [FSP_ADDR_W-1:0] pointer_addr,
  input wire logic [15:0] word_source_pair,
  input wire logic [FSP_ADDR_W-1:0] nvm_address_register,
  input wire logic [15:0] crc_end_addr,
  input wire logic boot_lock_programmed,
  output logic [7:0] load_dest_data,
  output logic [15:0] register_a,
  output logic busy_flag,
  output logic section_busy_flag,
  output logic core_halt,
  output logic cmd_aborted,
  output logic [FSP_ADDR_W-1:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_byte,
  output logic flash_erase_page,
  output logic flash_erase_app,
  output logic flash_erase_sig,
  output logic flash_prog,
  output logic flash_prog_sig,
  output logic [FSP_PAGE_BITS-1:0] flash_page,
  output logic [FSP_WORD_BITS-1:0] flash_word,
  output logic [15:0] flash_wdata
);

  // ***********************************************
  // state
  // ***********************************************
  typedef enum logic [6:0] {
    FSP_IDLE   = 7'b000_0001,
    FSP_ERASE  = 7'b000_0010,
    FSP_PROG   = 7'b000_0100,
    FSP_CRC    = 7'b000_1000,
    FSP_BCLR   = 7'b001_0000,
    FSP_SCLR   = 7'b010_0000,
    FSP_ABORT  = 7'b100_0000
  } fsp_state_e;

  fsp_state_e state_reg, state_next;
  logic [FSP_TMR_W-1:0] tmr_reg, tmr_next;
  logic [FSP_PAGE_BITS-1:0] page_reg;
  logic [FSP_WORD_BITS-1:0] word_reg;
  logic prog_after_reg, sig_reg, app_all_reg, halt_reg, busy_out_reg, section_busy_flag_reg, abort_reg;
  logic [FSP_ADDR_W-1:0] crc_addr_reg, crc_end_reg;
  logic [15:0] crc_reg, data_reg;
  logic [7:0] load_reg;

  fsp_buf_if buf_bus ();

  fsp_page_buf u_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .bus(buf_bus)
  );

  // ***********************************************
  // decode
  // ***********************************************
  wire [FSP_PAGE_BITS-1:0] ptr_page = pointer_addr[FSP_PAGE_LSB +: FSP_PAGE_BITS];
  wire [FSP_WORD_BITS-1:0] ptr_word = pointer_addr[1 +: FSP_WORD_BITS];
  wire ptr_in_boot = ptr_page >= FSP_BOOT_FIRST_PAGE;
  wire idle = state_reg == FSP_IDLE;
  wire store_go = idle && program_memory_store_instr;
  wire exec_go = idle && command_execute_bit && unlock_ok;
  wire prot_store = store_go && unlock_ok;

  wire c_load = command_sel == FSP_CMD_LOAD_BUF;
  wire c_ebuf = command_sel == FSP_CMD_ERASE_BUF;
  wire c_erase_any = command_sel == FSP_CMD_ERASE_PAGE;
  wire c_write_any = command_sel == FSP_CMD_WRITE_PAGE;
  wire c_ew_any = command_sel == FSP_CMD_EW_PAGE;
  wire c_rcrc = command_sel == FSP_CMD_RANGE_CRC;
  wire c_eapp = command_sel == FSP_CMD_ERASE_APP;
  wire c_app_e = command_sel == FSP_CMD_ERASE_APP_PG;
  wire c_app_w = command_sel == FSP_CMD_WRITE_APP_PG;
  wire c_app_ew = command_sel == FSP_CMD_EW_APP_PG;
  wire c_acrc = command_sel == FSP_CMD_APP_CRC;
  wire c_boot_e = command_sel == FSP_CMD_ERASE_BOOT_PG;
  wire c_boot_w = command_sel == FSP_CMD_WRITE_BOOT_PG;
  wire c_boot_ew = command_sel == FSP_CMD_EW_BOOT_PG;
  wire c_bcrc = command_sel == FSP_CMD_BOOT_CRC;
  wire c_esig = command_sel == FSP_CMD_ERASE_SIG;
  wire c_wsig = command_sel == FSP_CMD_WRITE_SIG;

  wire app_pg = c_app_e || c_app_w || c_app_ew;
  wire boot_pg = c_boot_e || c_boot_w || c_boot_ew;
  wire wrong_sec = (app_pg && ptr_in_boot) || (boot_pg && !ptr_in_boot);
  wire pg_erase = c_erase_any || c_app_e || c_boot_e;
  wire pg_write = c_write_any || c_app_w || c_boot_w;
  wire pg_ew = c_ew_any || c_app_ew || c_boot_ew;
  wire pg_cmd = pg_erase || pg_write || pg_ew;
  wire start_page = prot_store && pg_cmd && !wrong_sec;
  wire start_eapp = prot_store && c_eapp && !ptr_in_boot;
  wire start_esig = prot_store && c_esig;
  wire start_wsig = prot_store && c_wsig;
  wire start_ebuf = exec_go && c_ebuf;
  wire crc_cmd = c_rcrc || c_acrc || c_bcrc;
  wire start_crc = exec_go && crc_cmd && !(c_rcrc && boot_lock_programmed);
  wire start_abort = (prot_store && ((pg_cmd && wrong_sec) || (c_eapp && ptr_in_boot)))
                     || (exec_go && c_rcrc && boot_lock_programmed);

  wire [FSP_ADDR_W-1:0] crc_lo = c_rcrc ? nvm_address_register :
                                 c_bcrc ? {1'b0, FSP_BOOT_FIRST_PAGE, {FSP_PAGE_LSB{1'b0}}} : '0;
  wire [FSP_ADDR_W-1:0] crc_hi = c_rcrc ? crc_end_addr :
                                 c_acrc ? {1'b0, FSP_BOOT_FIRST_PAGE, {FSP_PAGE_LSB{1'b0}}} - 16'h0001 :
                                 16'hFFFF;
  wire crc_last = crc_addr_reg == crc_end_reg;
  wire tmr_done = tmr_reg == '0;
  wire [15:0] crc_step;

  fsp_crc16 u_crc (
    .crc_in(crc_reg),
    .byte_in(flash_rd_byte),
    .crc_out(crc_step)
  );

  // ***********************************************
  // sequence
  // ***********************************************
  always_comb
  begin
    state_next = state_reg;
    tmr_next = tmr_done ? tmr_reg : tmr_reg - 1'b1;
    unique case (state_reg)
      FSP_IDLE:
      begin
        if (start_page && !pg_write)
        begin
          state_next = FSP_ERASE;
          tmr_next = FSP_TMR_W'(FSP_ERASE_CYC - 1);
        end
        else if (start_page || start_wsig)
        begin
          state_next = FSP_PROG;
          tmr_next = FSP_TMR_W'(FSP_PROG_CYC - 1);
        end
        else if (start_eapp || start_esig)
        begin
          state_next = FSP_ERASE;
          tmr_next = FSP_TMR_W'(FSP_ERASE_CYC - 1);
        end
        else if (start_crc)
          state_next = FSP_CRC;
        else if (start_ebuf)
          state_next = FSP_BCLR;
        else if (start_abort)
          state_next = FSP_ABORT;
      end
      FSP_ERASE:
        if (tmr_done)
        begin
          state_next = prog_after_reg ? FSP_PROG : FSP_IDLE;
          tmr_next = FSP_TMR_W'(FSP_PROG_CYC - 1);
        end
      FSP_PROG:
        if (tmr_done && word_reg == FSP_WORD_BITS'(FSP_PAGE_WORDS - 1))
          state_next = sig_reg ? FSP_SCLR : FSP_IDLE;
      FSP_CRC:
        if (crc_last)
          state_next = FSP_IDLE;
      FSP_BCLR:
        state_next = FSP_IDLE;
      FSP_SCLR:
        state_next = FSP_IDLE;
      FSP_ABORT:
        state_next = FSP_IDLE;
      default:
        state_next = FSP_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg <= FSP_IDLE;
      tmr_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      page_reg <= '0;
      word_reg <= '0;
      prog_after_reg <= 1'b0;
      sig_reg <= 1'b0;
      app_all_reg <= 1'b0;
      crc_addr_reg <= '0;
      crc_end_reg <= '0;
      crc_reg <= FSP_CRC_SEED;
    end
    else if (idle)
    begin
      page_reg <= ptr_page;
      word_reg <= '0;
      prog_after_reg <= pg_ew;
      sig_reg <= c_wsig || c_esig;
      app_all_reg <= c_eapp;
      crc_addr_reg <= crc_lo;
      crc_end_reg <= crc_hi;
      crc_reg <= FSP_CRC_SEED;
    end
    else
    begin
      if (state_reg == FSP_PROG && tmr_done)
        word_reg <= word_reg + 1'b1;
      if (state_reg == FSP_CRC)
      begin
        crc_reg <= crc_step;
        crc_addr_reg <= crc_addr_reg + 1'b1;
      end
    end
  end

  // halt only for section erase, crc, signature row and boot-page work
  wire halting = (state_next == FSP_ERASE || state_next == FSP_PROG || state_next == FSP_CRC)
                 && (idle ? (crc_cmd || c_eapp || c_esig || c_wsig || boot_pg ||
                             ((c_erase_any || c_write_any || c_ew_any) && ptr_in_boot))
                          : halt_reg);

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      halt_reg <= 1'b0;
      busy_out_reg <= 1'b0;
      section_busy_flag_reg <= 1'b0;
      abort_reg <= 1'b0;
      data_reg <= '0;
      load_reg <= '0;
    end
    else
    begin
      halt_reg <= halting;
      busy_out_reg <= state_next != FSP_IDLE && state_next != FSP_ABORT && state_next != FSP_SCLR;
      section_busy_flag_reg <= state_next == FSP_ERASE || state_next == FSP_PROG;
      abort_reg <= state_next == FSP_ABORT || (abort_reg && !(start_page || start_crc));
      if (state_reg == FSP_CRC && crc_last)
        data_reg <= crc_step;
      if (idle && program_memory_load_instr && command_sel == FSP_CMD_NOP)
        load_reg <= flash_rd_byte;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign buf_bus.wr_en = store_go && c_load;
  assign buf_bus.wr_idx = ptr_word;
  assign buf_bus.wr_data = word_source_pair;
  assign buf_bus.clear = state_reg == FSP_BCLR || state_reg == FSP_SCLR;
  assign buf_bus.rd_idx = word_reg;

  assign flash_rd_addr = state_reg == FSP_CRC ? crc_addr_reg : pointer_addr;
  assign load_dest_data = load_reg;
  assign register_a = data_reg;
  assign busy_flag = busy_out_reg;
  assign section_busy_flag = section_busy_flag_reg;
  assign core_halt = halt_reg;
  assign cmd_aborted = abort_reg;
  assign flash_erase_page = state_reg == FSP_ERASE && tmr_done && !app_all_reg && !sig_reg;
  assign flash_erase_app = state_reg == FSP_ERASE && tmr_done && app_all_reg;
  assign flash_erase_sig = state_reg == FSP_ERASE && tmr_done && sig_reg;
  assign flash_prog = state_reg == FSP_PROG && tmr_done && !sig_reg;
  assign flash_prog_sig = state_reg == FSP_PROG && tmr_done && sig_reg;
  assign flash_page = page_reg;
  assign flash_word = word_reg;
  assign flash_wdata = buf_bus.rd_data;

  // ***********************************************
  // checks
  // ***********************************************
  a_unlock_needed: assert property (@(posedge mclk) disable iff (!reset_n)
    idle && !unlock_ok |=> state_reg == FSP_IDLE)
    else $error("protected trigger took effect without unlock");
  a_load_no_unlock: assert property (@(posedge mclk) disable iff (!reset_n)
    idle && program_memory_store_instr && c_load && !unlock_ok |-> buf_bus.wr_en)
    else $error("buffer load refused without unlock");
  a_ebuf_busy: assert property (@(posedge mclk) disable iff (!reset_n)
    start_ebuf |=> busy_flag ##1 !busy_flag)
    else $error("buffer erase busy wrong");
  a_section_busy_flag_tracks: assert property (@(posedge mclk) disable iff (!reset_n)
    section_busy_flag |-> busy_flag)
    else $error("section busy without busy");
  a_wrong_section: assert property (@(posedge mclk) disable iff (!reset_n)
    idle && program_memory_store_instr && unlock_ok && app_pg && ptr_in_boot |=> cmd_aborted && !busy_flag)
    else $error("wrong-section page command not aborted");
  a_crc_lock: assert property (@(posedge mclk) disable iff (!reset_n)
    exec_go && c_rcrc && boot_lock_programmed |=> state_reg == FSP_ABORT)
    else $error("range crc ran with boot lock set");
  a_crc_halt: assert property (@(posedge mclk) disable iff (!reset_n)
    start_crc |=> core_halt && busy_flag)
    else $error("crc without halt or busy");
  a_ew_order: assert property (@(posedge mclk) disable iff (!reset_n)
    state_reg == FSP_ERASE && tmr_done && prog_after_reg |=> state_reg == FSP_PROG && busy_flag)
    else $error("erase-write not atomic");
  a_sig_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    state_reg == FSP_SCLR |-> buf_bus.clear && !core_halt)
    else $error("signature buffer clear wrong");
  a_eapp_halt: assert property (@(posedge mclk) disable iff (!reset_n)
    start_eapp |=> core_halt && section_busy_flag)
    else $error("app erase did not halt");

endmodule // fsp_sequencer

// *** test/fsp_flash_model.sv ***
/*
  Behavioural flash array facing the sequencer: answers byte reads at once
  and records the page and the words that the sequencer programs.
  Assumes one clock, strobes that last one cycle.
*/
`timescale 1ns/1ps
module fsp_flash_model
  import fsp_pkg::*;
(
  input wire logic mclk,
  input wire logic [FSP_ADDR_W-1:0] flash_rd_addr,
  output logic [7:0] flash_rd_byte,
  input wire logic flash_erase_page,
  input wire logic flash_prog,
  input wire logic [FSP_PAGE_BITS-1:0] flash_page,
  input wire logic [FSP_WORD_BITS-1:0] flash_word,
  input wire logic [15:0] flash_wdata
);
  // ***********************************************
  // array contents
  // ***********************************************
  logic [15:0] mem [0:FSP_PAGE_WORDS-1];
  logic [FSP_PAGE_BITS-1:0] pg = '0;
  int n_prog = 0;

  // address-dependent pattern, so a wrong read address shows up
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  assign flash_rd_byte = byte_at(flash_rd_addr);

  always @(posedge mclk)
  begin
    if (flash_prog)
    begin
      mem[flash_word] <= flash_wdata;
      pg <= flash_page;
      n_prog <= n_prog + 1;
    end
    if (flash_erase_page)
      pg <= flash_page;
  end
endmodule // fsp_flash_model

// *** test/tb.sv ***
/*
  Self-checking bench for the flash self-program sequencer.
  Assumes the flash model in fsp_flash_model and the package timing counts.
*/
`timescale 1ns/1ps
module tb;
  import fsp_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] command_sel = 7'h00;
  logic command_execute_bit = 1'b0;
  logic unlock_ok = 1'b0;
  logic program_memory_load_instr = 1'b0;
  logic program_memory_store_instr = 1'b0;
  logic [15:0] pointer_addr = 16'h0000;
  logic [15:0] word_source_pair = 16'h0000;
  logic [15:0] nvm_address_register = 16'h0000;
  logic [15:0] crc_end_addr = 16'h0000;
  logic boot_lock_programmed = 1'b0;
  logic [7:0] load_dest_data;
  logic [15:0] register_a;
  logic busy_flag;
  logic section_busy_flag;
  logic core_halt;
  logic cmd_aborted;
  logic [15:0] flash_rd_addr;
  logic [7:0] flash_rd_byte;
  logic flash_erase_page;
  logic flash_erase_app;
  logic flash_erase_sig;
  logic flash_prog_sig;
  logic [2:0] strobe_seen = 3'h0;
  int n_psig = 0;
  logic flash_prog;
  logic [8:0] flash_page;
  logic [4:0] flash_word;
  logic [15:0] flash_wdata;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int busy_cyc = 0;
  logic sb_seen = 1'b0;
  logic halt_seen = 1'b0;
  logic abort_seen = 1'b0;

  always #50 mclk = ~mclk;

  fsp_sequencer fsp_sequencer_i (.mclk(mclk), .reset_n(reset_n), .command_sel(command_sel),
    .command_execute_bit(command_execute_bit), .unlock_ok(unlock_ok),
    .program_memory_load_instr(program_memory_load_instr),
    .program_memory_store_instr(program_memory_store_instr), .pointer_addr(pointer_addr),
    .word_source_pair(word_source_pair), .nvm_address_register(nvm_address_register),
    .crc_end_addr(crc_end_addr), .boot_lock_programmed(boot_lock_programmed),
    .load_dest_data(load_dest_data), .register_a(register_a), .busy_flag(busy_flag),
    .section_busy_flag(section_busy_flag), .core_halt(core_halt), .cmd_aborted(cmd_aborted),
    .flash_rd_addr(flash_rd_addr), .flash_rd_byte(flash_rd_byte), .flash_erase_page(flash_erase_page),
    .flash_erase_app(flash_erase_app), .flash_erase_sig(flash_erase_sig), .flash_prog(flash_prog),
    .flash_prog_sig(flash_prog_sig),
    .flash_page(flash_page), .flash_word(flash_word), .flash_wdata(flash_wdata));

  fsp_flash_model fsp_flash_model_i (.mclk(mclk), .flash_rd_addr(flash_rd_addr), .flash_rd_byte(flash_rd_byte),
    .flash_erase_page(flash_erase_page), .flash_prog(flash_prog), .flash_page(flash_page),
    .flash_word(flash_word), .flash_wdata(flash_wdata));

  // ***********************************************
  // monitor and timeout
  // ***********************************************
  always @(posedge mclk)
  begin
    cyc++;
    if (busy_flag === 1'b1) busy_cyc++;
    if (section_busy_flag === 1'b1) sb_seen = 1'b1;
    if (core_halt === 1'b1) halt_seen = 1'b1;
    if (cmd_aborted === 1'b1) abort_seen = 1'b1;
    if (flash_prog_sig === 1'b1) n_psig++;
    strobe_seen = strobe_seen | {flash_erase_sig === 1'b1, flash_erase_app === 1'b1, flash_erase_page === 1'b1};
    if (cyc == 60000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // kind: 0 execute bit, 1 store pulse, 2 load pulse
  task automatic fire(input logic [6:0] c, input logic [15:0] p, input int k, input logic ul);
    @(posedge mclk) #1;
    busy_cyc = 0;
    sb_seen = 1'b0;
    halt_seen = 1'b0;
    abort_seen = 1'b0;
    strobe_seen = 3'h0;
    command_sel = c;
    pointer_addr = p;
    unlock_ok = ul;
    command_execute_bit = (k == 0);
    program_memory_store_instr = (k == 1);
    program_memory_load_instr = (k == 2);
    @(posedge mclk) #1;
    command_execute_bit = 1'b0;
    program_memory_store_instr = 1'b0;
    program_memory_load_instr = 1'b0;
    unlock_ok = 1'b0;
  endtask

  task automatic done(input int lim);
    int i;
    i = 0;
    while (busy_flag !== 1'b0 && i < lim)
    begin
      @(posedge mclk) #1;
      i++;
    end
    repeat (2) @(posedge mclk);
    #1;
    check(busy_flag, 1'b0);
  endtask

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) r = r[15] ? ((r << 1) ^ FSP_CRC_POLY) : (r << 1);
    return r;
  endfunction

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_read();
    fire(FSP_CMD_NOP, 16'h1234, 2, 1'b0);
    check(load_dest_data, fsp_flash_model_i.byte_at(16'h1234));
    check(busy_cyc, 0);
  endtask

  task automatic t_buffer_write();
    fire(FSP_CMD_ERASE_BUF, 16'h0000, 0, 1'b1);
    done(10);
    check(busy_cyc, 1);
    word_source_pair = 16'hA5C3;
    fire(FSP_CMD_LOAD_BUF, 16'h0006, 1, 1'b0);
    // stray low bits must not move the target page
    fire(FSP_CMD_WRITE_PAGE, 16'h017F, 1, 1'b1);
    done(34000);
    check(fsp_flash_model_i.pg, 9'h005);
    check(fsp_flash_model_i.mem[3], 16'hA5C3);
    check(fsp_flash_model_i.mem[7], FSP_BLANK_WORD);
    check(fsp_flash_model_i.n_prog, FSP_PAGE_WORDS);
    check(sb_seen, 1'b1);
  endtask

  task automatic t_erase_page();
    fire(FSP_CMD_ERASE_PAGE, 16'h0A85, 1, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    check(busy_cyc, 0);
    fire(FSP_CMD_ERASE_PAGE, 16'h0A85, 1, 1'b1);
    done(1100);
    check(busy_cyc, FSP_ERASE_CYC);
    check(fsp_flash_model_i.pg, 9'h02A);
    check(sb_seen, 1'b1);
  endtask

  task automatic t_wrong_section();
    logic [22:0] tbl [4] = '{{7'h22, 16'h7800}, {7'h2A, 16'h0040}, {7'h2D, 16'h0040}, {7'h25, 16'h7800}};
    nvm_address_register = 16'h0000;
    crc_end_addr = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      // a one-byte crc clears the held abort flag, so each abort is seen afresh
      fire(FSP_CMD_RANGE_CRC, 16'h0000, 0, 1'b1);
      done(10);
      check(cmd_aborted, 1'b0);
      fire(tbl[i][22:16], tbl[i][15:0], 1, 1'b1);
      repeat (3) @(posedge mclk);
      #1;
      check(abort_seen, 1'b1);
      check(busy_cyc, 0);
    end
  endtask

  task automatic t_erase_codes();
    logic [26:0] tbl [4] = '{{7'h20, 16'h0040, 4'hA}, {7'h22, 16'h0040, 4'h1},
                             {7'h2A, 16'h7840, 4'h9}, {7'h18, 16'h0000, 4'hC}};
    for (int i = 0; i < 4; i++)
    begin
      fire(tbl[i][26:20], tbl[i][19:4], 1, 1'b1);
      done(1100);
      check(busy_cyc, FSP_ERASE_CYC);
      check(halt_seen, tbl[i][3]);
      check(strobe_seen, tbl[i][2:0]);
    end
  endtask

  task automatic t_sig_write();
    word_source_pair = 16'h1234;
    fire(FSP_CMD_LOAD_BUF, 16'h0000, 1, 1'b0);
    check(flash_wdata, 16'h1234);
    fire(FSP_CMD_EW_APP_PG, 16'h0080, 1, 1'b1);
    done(2100);
    check(busy_cyc, FSP_ERASE_CYC + FSP_PROG_CYC + FSP_PAGE_WORDS - 1);
    check(fsp_flash_model_i.pg, 9'h002);
    check(fsp_flash_model_i.mem[0], 16'h1234);
    check(strobe_seen, 3'h1);
    check(halt_seen, 1'b0);
    fire(FSP_CMD_WRITE_SIG, 16'h0000, 1, 1'b1);
    done(1100);
    check(busy_cyc, FSP_PROG_CYC + FSP_PAGE_WORDS - 1);
    check(n_psig, FSP_PAGE_WORDS);
    check(halt_seen, 1'b1);
    check(flash_wdata, FSP_BLANK_WORD);
  endtask

  task automatic t_range_crc();
    logic [15:0] exp;
    nvm_address_register = 16'h0100;
    crc_end_addr = 16'h0103;
    boot_lock_programmed = 1'b1;
    check(cmd_aborted, 1'b0);
    fire(FSP_CMD_RANGE_CRC, 16'h0000, 0, 1'b1);
    repeat (3) @(posedge mclk);
    #1;
    check(abort_seen, 1'b1);
    check(busy_cyc, 0);
    boot_lock_programmed = 1'b0;
    fire(FSP_CMD_RANGE_CRC, 16'h0000, 0, 1'b1);
    done(50);
    exp = FSP_CRC_SEED;
    for (int a = 16'h0100; a <= 16'h0103; a++) exp = crc_upd(exp, fsp_flash_model_i.byte_at(a[15:0]));
    check(register_a, exp);
    check(halt_seen, 1'b1);
  endtask

  initial
  begin
    repeat (4) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    check(busy_flag, 1'b0);
    check(cmd_aborted, 1'b0);
    t_read();
    t_buffer_write();
    t_erase_page();
    t_wrong_section();
    t_erase_codes();
    t_sig_write();
    t_range_crc();
    report_and_stop();
  end
endmodule // tb
